// ---- src/program_sequencer_pkg.sv ----
// Purpose: shared constants for the program sequencer
// Assumes: one clock, ten-bit program counter, sixteen-bit instructions
// Notes:   operation codes are coded by the decoder outside this block
package program_sequencer_pkg;
  // ==========================================================
  // widths and sizes
  localparam int PC_W        = 10;
  localparam int INSN_W      = 16;
  localparam int OPND_W      = 11;
  localparam int STACK_DEPTH = 5;
  localparam int ROM_SMALL   = 768;
  localparam int ROM_LARGE   = 1024;
  // ==========================================================
  // fixed addresses
  localparam logic [9:0]  RESET_VEC  = 10'h000;
  localparam logic [9:0]  SERIAL_VEC = 10'h001;
  localparam logic [9:0]  TIMER_VEC  = 10'h002;
  localparam logic [9:0]  EXTPIN_VEC = 10'h003;
  localparam logic [9:0]  PC_STEP    = 10'h001;
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  // ==========================================================
  // operation selected by the decoder
  typedef enum logic [3:0] {
    OP_SEQ        = 4'h0,
    OP_BRANCH     = 4'h1,
    OP_BRANCH_IND = 4'h2,
    OP_CALL       = 4'h3,
    OP_CALL_IND   = 4'h4,
    OP_RETURN     = 4'h5,
    OP_TABLE      = 4'h6,
    OP_SKIP       = 4'h7
  } seq_op_e;
  // interrupt source selector
  typedef enum logic [1:0] {
    IRQ_SERIAL = 2'h0,
    IRQ_TIMER  = 2'h1,
    IRQ_EXTPIN = 2'h2
  } irq_src_e;
  // sequencer state
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_TABLE = 1'b1
  } seq_state_e;
endpackage

// ---- src/program_sequencer.sv ----
// Purpose: program counter, return stack, table read and instruction rom
// Assumes: decoder presents one operation per execStep with its operand
// Notes:   rom contents come from parameter romImage, no write path exists
`timescale 1ns/1ps
`default_nettype none

// Contract
// - returns pop stack top into counter
// - table read pushes, fetches at address register, pops
// - table read holds one stack level meanwhile
// - true skip turns next instruction into nop
// - skip timing same whether taken or not
// - interrupt pushes counter then loads its vector
// - ten-bit binary counter, up to 1024 words
// - small rom reads all ones above end
// - counter keeps counting past last word
// - rom 768 or 1024 words from zero
// - one sixteen-bit word per instruction fetch
// - instruction memory is read-only
// - vectors zero, one, two, three fixed
// - direct branch loads low operand bits
// - indirect branch loads address register, stack untouched
// - direct call pushes then loads operand
// - otherwise step one location at a time
// - low reset clears program counter
// - indirect call pushes then loads address register
// - table read two cycles, others one
module program_sequencer #(
  parameter int ROM_WORDS = program_sequencer_pkg::ROM_SMALL,
  parameter logic [program_sequencer_pkg::INSN_W-1:0]
    romImage [program_sequencer_pkg::ROM_LARGE] =
    '{default: program_sequencer_pkg::BLANK_WORD}
) (
  // clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   rst_n,
  // operation from the decoder
  input  wire logic                                   execStep,
  input  wire program_sequencer_pkg::seq_op_e         seqOp,
  input  wire logic [program_sequencer_pkg::OPND_W-1:0] operand,
  input  wire logic                                   skipCond,
  // interrupt acceptance
  input  wire logic                                   irqTake,
  input  wire program_sequencer_pkg::irq_src_e        irqSrc,
  // address register contents
  input  wire logic [program_sequencer_pkg::PC_W-1:0] address_register,
  // fetch and table results
  output logic [program_sequencer_pkg::PC_W-1:0]      program_counter,
  output logic [program_sequencer_pkg::INSN_W-1:0]    insnWord,
  output logic                                        insnNop,
  output logic [program_sequencer_pkg::INSN_W-1:0]    data_buffer,
  output logic                                        tableDone,
  output logic                                        busy,
  output logic [2:0]                                  stackLevel,
  output logic                                        stackFault
);
  import program_sequencer_pkg::*;

  // ==========================================================
  // state
  logic [PC_W-1:0]   pc_r;                      // program counter
  logic [PC_W-1:0]   stack_r [STACK_DEPTH];     // return stack
  logic [2:0]        sp_r;                      // entries in use
  seq_state_e        state_r;                   // run or table phase
  logic              skipNext_r;                // next insn is nop
  logic [INSN_W-1:0] word_r;                    // fetched word
  logic [INSN_W-1:0] dbuf_r;                    // table result
  logic              done_r;                    // table done pulse
  logic              fault_r;                   // stack misuse flag
  logic [PC_W-1:0]   vecAddr;                   // chosen vector
  logic              doPush;                    // push this cycle
  logic              doPop;                     // pop this cycle
  logic [PC_W-1:0]   pushVal;                   // value pushed
  logic [PC_W-1:0]   pc_nxt;                    // next counter
  logic [PC_W-1:0]   fetchAddr;                 // rom address
  logic              inTable;                   // table phase now
  logic              fetchBlank;                // fetch beyond rom end
  logic              stackRoom;                 // a push still fits
  logic [PC_W-1:0]   stackTop;                  // newest entry
  logic              nop_r;                     // nop marker
  logic              busy_r;                    // table phase marker

  // ==========================================================
  // vector select, fixed codes only
  // a code with no source falls back to the reset vector
  always_comb begin
    case (irqSrc)
      IRQ_SERIAL: vecAddr = SERIAL_VEC;
      IRQ_TIMER:  vecAddr = TIMER_VEC;
      IRQ_EXTPIN: vecAddr = EXTPIN_VEC;
      default:    vecAddr = RESET_VEC;
    endcase
  end

  // ==========================================================
  // next counter and stack moves
  // priority: table phase, then interrupt, then the instruction
  // an interrupt in a skip step leaves the skip pending for later
  assign inTable = (state_r == ST_TABLE);
  // room check kept apart so push and flag agree on full
  assign stackRoom = (sp_r < 3'(STACK_DEPTH));
  // stack top; an empty stack yields the reset vector, not garbage
  assign stackTop = (sp_r == 3'h0) ? RESET_VEC : stack_r[sp_r - 3'h1];
  always_comb begin
    doPush  = 1'b0;
    doPop   = 1'b0;
    pushVal = pc_r;
    pc_nxt  = pc_r;
    if (inTable) begin
      // second cycle: restore saved counter
      doPop  = 1'b1;
      pc_nxt = stackTop;
    end else if (irqTake) begin
      // interrupt wins over the instruction in this step
      doPush = 1'b1;
      pc_nxt = vecAddr;
    end else if (execStep) begin
      // counter wraps only at ten bits, never at rom end
      pc_nxt = pc_r + PC_STEP;
      if (!skipNext_r) begin
        case (seqOp)
          OP_BRANCH: pc_nxt = operand[PC_W-1:0];
          OP_BRANCH_IND: pc_nxt = address_register;
          OP_CALL: begin
            doPush  = 1'b1;
            pushVal = pc_r + PC_STEP;
            pc_nxt  = operand[PC_W-1:0];
          end
          OP_CALL_IND: begin
            doPush  = 1'b1;
            pushVal = pc_r + PC_STEP;
            pc_nxt  = address_register;
          end
          OP_RETURN: begin
            doPop  = 1'b1;
            pc_nxt = stackTop;
          end
          OP_TABLE: begin
            // save the return point, hold one level meanwhile
            doPush  = 1'b1;
            pushVal = pc_r + PC_STEP;
            pc_nxt  = pc_r;
          end
          default: pc_nxt = pc_r + PC_STEP;
        endcase
      end
    end
  end

  // ==========================================================
  // rom address: table phase reads at address register
  assign fetchAddr = inTable ? address_register : pc_r;
  // beyond the end of the smaller rom nothing is implemented
  assign fetchBlank = (int'(fetchAddr) >= ROM_WORDS);

  // ==========================================================
  // program counter
  // only reset and the next-value logic ever load it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= RESET_VEC;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // ==========================================================
  // return stack storage, lifo; a push at full depth is dropped
  // so the oldest return points survive an overflow
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= RESET_VEC;
      end
    end else if (doPush && stackRoom) begin
      stack_r[sp_r] <= pushVal;
    end
  end

  // ==========================================================
  // stack pointer, counts entries in use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= 3'h0;
    end else if (doPush) begin
      if (stackRoom) begin
        sp_r <= sp_r + 3'h1;
      end
    end else if (doPop && sp_r != 3'h0) begin
      sp_r <= sp_r - 3'h1;
    end
  end

  // ==========================================================
  // sticky misuse flag: push when full or pop when empty
  // only reset clears it, so a late look still sees it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (doPush && !stackRoom) begin
      fault_r <= 1'b1;
    end else if (doPop && sp_r == 3'h0) begin
      fault_r <= 1'b1;
    end
  end

  // ==========================================================
  // table read phase, one extra cycle
  // steps offered during that cycle are dropped, not queued
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (execStep && !irqTake && !skipNext_r && seqOp == OP_TABLE) begin
            state_r <= ST_TABLE;
          end
        end
        ST_TABLE: state_r <= ST_RUN;
        default:  state_r <= ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // skip marker: following step executes as nop, still one step
  // a skipped step is never decoded, so skips cannot chain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      skipNext_r <= 1'b0;
    end else if (execStep && !irqTake && !inTable) begin
      skipNext_r <= !skipNext_r && seqOp == OP_SKIP && skipCond;
    end
  end

  // ==========================================================
  // instruction fetch, one whole word per address
  // above the end of a small rom the read is blank, never aliased
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= BLANK_WORD;
    end else if (fetchBlank) begin
      word_r <= BLANK_WORD;
    end else begin
      word_r <= romImage[fetchAddr];
    end
  end

  // ==========================================================
  // data buffer, loaded only in the table phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dbuf_r <= ZERO_WORD;
    end else if (inTable) begin
      // same path as a fetch, so constants read like instructions
      dbuf_r <= fetchBlank ? BLANK_WORD : romImage[fetchAddr];
    end
  end

  // ==========================================================
  // table done pulse, one cycle after the table fetch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= inTable;
    end
  end

  // ==========================================================
  // nop marker, lines up with the word of the skipped step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nop_r <= 1'b0;
    end else begin
      nop_r <= skipNext_r;
    end
  end

  // ==========================================================
  // busy marker, one cycle late copy of the table phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= inTable;
    end
  end

  // ==========================================================
  // outputs straight from registers, no logic after the flops
  assign program_counter = pc_r;
  assign insnWord        = word_r;
  assign insnNop         = nop_r;
  assign data_buffer     = dbuf_r;
  assign tableDone       = done_r;
  assign busy            = busy_r;
  assign stackLevel      = sp_r;
  assign stackFault      = fault_r;
endmodule

`default_nettype wire

// ---- test/sequencer_monitor.sv ----
// Purpose: port checker for the program sequencer
// Assumes: one clock; table and skip state rebuilt here
// Notes:   a skip left pending across an interrupt is kept and judged at the next step
`timescale 1ns/1ps
`default_nettype none
module sequencer_monitor #(parameter int ROM_WORDS = 768) (
  // clock and reset
  input wire logic                              mclk,
  input wire logic                              rst_n,
  // decoder side
  input wire logic                              execStep,
  input wire program_sequencer_pkg::seq_op_e    seqOp,
  input wire logic [10:0]                       operand,
  input wire logic                              skipCond,
  input wire logic                              irqTake,
  input wire program_sequencer_pkg::irq_src_e   irqSrc,
  input wire logic [9:0]                        address_register,
  // results
  input wire logic [9:0]                        program_counter,
  input wire logic [15:0]                       insnWord,
  input wire logic                              tableDone,
  input wire logic                              busy,
  input wire logic [2:0]                        stackLevel,
  input wire logic                              insnNop,
  input wire logic                              stackFault
);
  import program_sequencer_pkg::*;
  logic      tab_r; // table fetch cycle
  logic      skp_r; // next step is a nop
  wire logic go  = execStep && !irqTake && !tab_r;
  wire logic act = go && !skp_r;
  // ==================================================
  // rebuild table phase and pending skip
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tab_r <= 1'b0;
      skp_r <= 1'b0;
    end else begin
      tab_r <= act && seqOp == OP_TABLE;
      if (go) skp_r <= act && seqOp == OP_SKIP && skipCond;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // table read: hold with one level in use, then resume
  sequence tabHold;
    program_counter == $past(program_counter)
      && stackLevel == $past(stackLevel) + 3'h1;
  endsequence
  sequence tabBack;
    program_counter == $past(program_counter, 2) + PC_STEP
      && tableDone && busy && stackLevel == $past(stackLevel, 2);
  endsequence
  seq_step_a: assert property (act && seqOp == OP_SEQ |=>
    program_counter == $past(program_counter) + PC_STEP) else $error("step");
  skip_nop_a: assert property (go && skp_r |=> $stable(stackLevel)
    && program_counter == $past(program_counter) + PC_STEP) else $error("nop");
  branch_load_a: assert property (act && seqOp == OP_BRANCH |=>
    program_counter == $past(operand[9:0])) else $error("branch");
  indirect_jump_a: assert property (act && seqOp == OP_BRANCH_IND |=>
    program_counter == $past(address_register) && $stable(stackLevel))
    else $error("indirect");
  call_push_a: assert property (act && stackLevel < 3'h5 &&
    seqOp inside {OP_CALL, OP_CALL_IND} |=>
    stackLevel == $past(stackLevel) + 3'h1) else $error("call");
  return_pop_a: assert property (act && seqOp == OP_RETURN &&
    stackLevel != 3'h0 |=> stackLevel == $past(stackLevel) - 3'h1)
    else $error("return");
  irq_vector_a: assert property (irqTake && !tab_r &&
    irqSrc != 2'h3 |=> program_counter == {8'h00, $past(irqSrc)} + PC_STEP)
    else $error("vector");
  table_read_a: assert property (act && seqOp == OP_TABLE &&
    stackLevel < 3'h5 |=> tabHold ##1 tabBack) else $error("table");
  rom_blank_a: assert property ($past(rst_n) && !$past(tab_r) &&
    $past(program_counter) >= ROM_WORDS |-> insnWord == BLANK_WORD)
    else $error("blank");
  nop_flag_a: assert property (go |=> insnNop == $past(skp_r))
    else $error("nop flag");
  stack_full_a: assert property (act && stackLevel == 3'h5 &&
    seqOp inside {OP_CALL, OP_CALL_IND} |=> stackFault
    && stackLevel == 3'h5) else $error("overflow");
  fault_clear_a: assert property (!stackFault && act &&
    seqOp inside {OP_CALL, OP_CALL_IND} && stackLevel < 3'h5
    |=> !stackFault) else $error("fault");
endmodule
bind program_sequencer sequencer_monitor #(.ROM_WORDS(ROM_WORDS)) i_mon (.*);
`default_nettype wire

// ---- test/instr_rom_model.sv ----
// Purpose: behavioural instruction rom seen from the far side
// Assumes: image pattern matches the one the bench loads
// Notes:   words past the end read as all ones
`timescale 1ns/1ps
`default_nettype none
module instr_rom_model #(parameter int WORDS = 768) (
  // fetch address and word
  input wire logic [9:0] addr,
  output logic [15:0]    word
);
  // no write port at all, contents fixed at build
  assign word = (addr < WORDS) ? ({addr[5:0], addr} ^ 16'hC3A5)
                               : 16'hFFFF;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: self-checking bench for the program sequencer
// Assumes: rom image built from a fixed pattern
// Notes:   no interrupt is taken while a skip is pending
`timescale 1ns/1ps
`default_nettype none
module tb;
  import program_sequencer_pkg::*;
  typedef logic [15:0] img_t [1024];
  // rom pattern shared with the partner model
  function automatic img_t mkImg();
    img_t m;
    for (int i = 0; i < 1024; i++) m[i] = {i[5:0], i[9:0]} ^ 16'hC3A5;
    return m;
  endfunction
  // lfsr for random traffic
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  logic mclk, rst_n, execStep, skipCond, irqTake, tableDone, skp, stackFault;
  seq_op_e  seqOp;
  irq_src_e irqSrc;
  logic [10:0] operand;
  logic [9:0]  address_register, program_counter, ep, ex;
  logic [15:0] data_buffer, romWord;
  logic [9:0]  stk[$], expQ[$];
  logic [7:0]  lf = 8'h62;
  int failures = 0, comparisons = 0, cyc = 0;
  program_sequencer #(.romImage(mkImg())) i_dut (.mclk(mclk), .rst_n(rst_n),
    .execStep(execStep), .seqOp(seqOp), .operand(operand),
    .skipCond(skipCond), .irqTake(irqTake), .irqSrc(irqSrc),
    .address_register(address_register), .program_counter(program_counter),
    .insnWord(), .insnNop(), .data_buffer(data_buffer),
    .tableDone(tableDone), .busy(), .stackLevel(),
    .stackFault(stackFault));
  instr_rom_model i_rom (.addr(address_register), .word(romWord));
  always #4 mclk = ~mclk;
  task automatic chk(input string nm, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ==================================================
  // one instruction step, expected counter queued
  task automatic step(input seq_op_e op, input logic [9:0] t, input logic c);
    logic [9:0] nx;
    nx = ep + 10'h001;
    if (!skp) begin
      if (op inside {OP_CALL, OP_CALL_IND}) stk.push_back(nx);
      if (op inside {OP_BRANCH, OP_BRANCH_IND, OP_CALL, OP_CALL_IND}) nx = t;
      if (op == OP_RETURN) nx = stk.pop_back();
    end
    skp = !skp && op == OP_SKIP && c;
    seqOp = op;
    operand = {1'b0, t};
    address_register = t;
    skipCond = c;
    execStep = 1'b1;
    irqTake = 1'b0;
    ep = nx;
    expQ.push_back(nx);
    @(posedge mclk); #1;
  endtask
  // table read; a branch offered in the fetch cycle must be ignored
  // the table address stays on address_register through the fetch cycle
  task automatic tbl(input logic [9:0] a);
    step(OP_TABLE, a, 1'b0);
    expQ[expQ.size() - 1] = ep - 10'h001;
    seqOp = OP_BRANCH;
    operand = 11'h3FF;
    expQ.push_back(ep);
    @(posedge mclk); #1;
    chk("data_buffer", data_buffer, romWord);
    chk("tableDone", {15'h0000, tableDone}, 16'h0001);
  endtask
  // accepted interrupt
  task automatic irq(input irq_src_e s);
    irqSrc = s;
    irqTake = 1'b1;
    execStep = 1'b0;
    stk.push_back(ep);
    ep = {8'h00, s} + 10'h001;
    expQ.push_back(ep);
    @(posedge mclk); #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watcher: oldest note against the counter after each step
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
    if (expQ.size() != 0) begin
      #2;
      ex = expQ.pop_front();
      chk("program_counter", {6'h00, program_counter}, {6'h00, ex});
    end
  end
  initial begin
    {mclk, rst_n, execStep, skipCond, irqTake, skp} = 6'h00;
    seqOp = OP_SEQ;
    irqSrc = IRQ_SERIAL;
    operand = 11'h000;
    address_register = 10'h000;
    ep = 10'h000;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("reset pc", {6'h00, program_counter}, 16'h0000);
    repeat (3) step(OP_SEQ, 10'h000, 1'b0);
    step(OP_SKIP, 10'h000, 1'b1);
    step(OP_BRANCH, 10'h200, 1'b0);
    step(OP_SKIP, 10'h000, 1'b0);
    step(OP_BRANCH, 10'h2FE, 1'b0);
    repeat (4) step(OP_SEQ, 10'h000, 1'b0);
    step(OP_CALL, 10'h100, 1'b0);
    step(OP_CALL_IND, 10'h155, 1'b0);
    tbl(10'h02A);
    tbl(10'h3A0);
    step(OP_RETURN, 10'h000, 1'b0);
    step(OP_RETURN, 10'h000, 1'b0);
    for (int s = 0; s < 3; s++) begin
      irq(irq_src_e'(s));
      step(OP_RETURN, 10'h000, 1'b0);
    end
    for (int n = 0; n < 80; n++) begin
      lf = nxt(lf);
      seqOp = seq_op_e'(lf[2:0]);
      if (seqOp == OP_TABLE || (seqOp == OP_RETURN && stk.size() == 0)
          || (seqOp inside {OP_CALL, OP_CALL_IND} && stk.size() > 3))
        seqOp = OP_SEQ;
      step(seqOp, {2'h0, lf}, lf[3]);
    end
    // fill the stack; one call too many is dropped and flagged
    while (stk.size() < 5) step(OP_CALL, 10'h010, 1'b0);
    chk("stackFault", {15'h0000, stackFault}, 16'h0000);
    step(OP_CALL, 10'h020, 1'b0);
    chk("stackFault", {15'h0000, stackFault}, 16'h0001);
    // reset in mid-run clears counter, stack and flag
    execStep = 1'b0;
    @(posedge mclk); #1;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("reset pc", {6'h00, program_counter}, 16'h0000);
    chk("stackFault", {15'h0000, stackFault}, 16'h0000);
    stk.delete();
    ep = 10'h000;
    skp = 1'b0;
    repeat (2) step(OP_SEQ, 10'h000, 1'b0);
    step(OP_CALL, 10'h040, 1'b0);
    step(OP_RETURN, 10'h000, 1'b0);
    execStep = 1'b0;
    repeat (2) @(posedge mclk);
    print_verdict();
  end
endmodule
`default_nettype wire
